// >>> rtl/fsrc_pkg.sv
// fsrc_pkg: constants, register map and state type of the flash security,
// interrupt and reset control block.
// assumes: one 250 MHz bus clock; registers reached over AHB-Lite.
package fsrc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int HOLD_TIME_NS = 100;
  localparam int HOLD_CYC     = (HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W       = 8;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_ERRCFG  = 8'h04;
  localparam logic [7:0] OFS_STAT    = 8'h08;
  localparam logic [7:0] OFS_ERRSTAT = 8'h0c;
  localparam logic [7:0] OFS_CIDX    = 8'h10;
  localparam logic [7:0] OFS_COBJ    = 8'h14;
  localparam logic [7:0] OFS_SEC     = 8'h18;
  localparam logic [7:0] OFS_PPROT   = 8'h1c;
  localparam logic [7:0] OFS_DPROT   = 8'h20;
  localparam logic [7:0] OFS_OPT     = 8'h24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_CMD_COMPLETE_IRQ_EN_BIT    = 0;
  localparam int ERR_SFD_BIT     = 0;
  localparam int ERR_DFD_BIT     = 1;
  localparam int STAT_CCF_BIT    = 7;
  localparam int STAT_ACCERR_BIT = 5;
  localparam int SEC_LSB         = 0;
  localparam int BACKDOOR_ENABLE_FIELD_LSB       = 6;

  // ---------------------------------------------------------------
  // encodings and defaults
  // ---------------------------------------------------------------
  localparam logic [1:0]  SEC_UNSECURE = 2'b10;
  localparam logic [1:0]  BACKDOOR_ENABLE_FIELD_ON     = 2'b10;
  localparam logic [1:0]  VERR_BOTH    = 2'b11;
  localparam logic [7:0]  SEC_DEF      = 8'hff;
  localparam logic [7:0]  PROT_DEF     = 8'h00;
  localparam logic [7:0]  OPT_DEF      = 8'hff;
  localparam logic [15:0] KEY_ALL0     = 16'h0000;
  localparam logic [15:0] KEY_ALL1     = 16'hffff;
  localparam logic [7:0]  CMD_VERIFY_KEY = 8'h0c;
  localparam logic [7:0]  CMD_EVERIFY_ALL = 8'h01;

  // ---------------------------------------------------------------
  // flash addresses of the configuration field
  // ---------------------------------------------------------------
  localparam logic [22:0] FA_KEY0 = 23'h7fff00;
  localparam logic [22:0] FA_PROT = 23'h7fff0c;
  localparam logic [22:0] FA_SECW = 23'h7fff0e;

  localparam int CCOB_DEPTH = 6;
  localparam int NUM_KEYS   = 4;
  localparam logic [2:0] CCOB_IDX_MAX = 3'd5;
  localparam logic [1:0] KEY_IDX_LAST = 2'd3;

  typedef enum logic [5:0] {
    S_HOLD = 6'b000001,
    S_CFG0 = 6'b000010,
    S_CFG1 = 6'b000100,
    S_IDLE = 6'b001000,
    S_KEY  = 6'b010000,
    S_CMD  = 6'b100000
  } fsrc_state_type;

endpackage

// >>> rtl/fsrc_key_chk.sv
// fsrc_key_chk: compares one presented backdoor key with one stored key.
// assumes: both words are stable for the cycle in which they are used.
`timescale 1ns/1ps
`default_nettype none
module fsrc_key_chk
  import fsrc_pkg::*;
(
  input  wire logic [15:0] presented,
  input  wire logic [15:0] stored,
  output logic             match,
  output logic             illegal
);

  // ---------------------------------------------------------------
  // compare
  // ---------------------------------------------------------------
  assign illegal = (presented == KEY_ALL0) || (presented == KEY_ALL1) ||
                   (stored == KEY_ALL0) || (stored == KEY_ALL1); // [RQ9]
  assign match   = (presented == stored) && !illegal; // [RQ7]

endmodule
`default_nettype wire

// >>> rtl/fsrc_ctrl.sv
// fsrc_ctrl: flash interrupt, low-power, security and reset-sequence control.
// assumes: AHB-Lite master on the same clock; flash array and command engine
// outside on the FL_* ports, answering reads with FL_RVALID.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RQ1] command irq = complete flag and enable
// [RQ2] error irq from either enabled fault flag
// [RQ3] runs unchanged in wait, irq wakes
// [RQ4] stop granted only once command completes
// [RQ5] security loaded from flash at reset
// [RQ6] new security byte applies after reset
// [RQ7] verify-key compares four 16-bit keys
// [RQ8] key match forces security state 10
// [RQ9] all-zero or all-one keys never valid
// [RQ10] block 0 reads invalid during verify-key
// [RQ11] illegal key locks verify-key until reset
// [RQ12] verify-key leaves stored config untouched
// [RQ13] debug erase, reset, verify-all unsecures
// [RQ14] reset loads config, errors give defaults
// [RQ15] reset double fault sets both verify bits
// [RQ16] reset holds bus, then ignores command writes
// [RQ17] complete flag set when reset sequence ends
// [RQ18] reset aborts running command at once
// [RQ19] flag in status, enable in configuration
// [RQ20] interrupt outputs are steady levels
module fsrc_ctrl
  import fsrc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             CMD_IRQ,
  output logic             ERR_IRQ,
  input  wire logic        STOP_REQ,
  output logic             STOP_ACK,
  input  wire logic        SPECIAL_MODE,
  output logic             PF0_BLOCKED,
  output logic             FL_RD,
  output logic [22:0]      FL_ADDR,
  input  wire logic [15:0] FL_RDATA,
  input  wire logic        FL_RVALID,
  input  wire logic        FL_SGL_FAULT,
  input  wire logic        FL_DBL_FAULT,
  output logic             FL_CMD_START,
  output logic [15:0]      FL_CMD_WORD0,
  output logic [15:0]      FL_CMD_WORD1,
  input  wire logic        FL_CMD_DONE,
  input  wire logic        FL_CMD_PASS
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fsrc_state_type      state_r;
  logic [HOLD_W-1:0]   hold_cnt_r;
  logic                rd_pend_r;
  logic [1:0]          key_idx_r;
  logic                key_ok_r;
  logic                key_lock_r;
  logic                cfg_err_r;
  logic [7:0]          prot_lo_r;
  logic                cmd_complete_flag;
  logic                acc_err_r;
  logic [1:0]          verify_error_status;
  logic                cmd_complete_irq_en;
  logic                single_fault_irq_en;
  logic                double_fault_irq_en;
  logic                single_fault_flag;
  logic                double_fault_flag;
  logic [2:0]          cmd_idx_r;
  logic [15:0]         ccob_r [CCOB_DEPTH];
  logic [7:0]          security_register;
  logic [7:0]          program_protect_register;
  logic [7:0]          data_protect_register;
  logic [7:0]          option_register;
  logic                dph_wr_r;
  logic [7:0]          dph_addr_r;
  logic [31:0]         hrdata_r;
  logic                addr_ok;
  logic                wr_cfg;
  logic                wr_errcfg;
  logic                wr_stat;
  logic                wr_errstat;
  logic                wr_cidx;
  logic                wr_cobj;
  logic                launch;
  logic                rd_done;
  logic                kc_match;
  logic                kc_illegal;
  logic [15:0]         key_presented;
  wire logic           key_refused = (ccob_r[0][15:8] == CMD_VERIFY_KEY) &&
                                     (security_register[BACKDOOR_ENABLE_FIELD_LSB +: 2] != BACKDOOR_ENABLE_FIELD_ON || key_lock_r);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // all access held off during the first part of the reset sequence
  assign HREADYOUT = (state_r != S_HOLD); // [RQ16]
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;
  assign addr_ok   = HSEL && HTRANS[1] && HREADY && HREADYOUT;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r   <= addr_ok && HWRITE;
      dph_addr_r <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE) begin
      if (HADDR[7:0] == OFS_CFG) begin
        hrdata_r <= {31'h0, cmd_complete_irq_en};
      end else if (HADDR[7:0] == OFS_ERRCFG) begin
        hrdata_r <= {30'h0, double_fault_irq_en, single_fault_irq_en};
      end else if (HADDR[7:0] == OFS_STAT) begin
        hrdata_r <= {24'h0, cmd_complete_flag, 1'b0, acc_err_r, 3'b000, verify_error_status}; // [RQ19]
      end else if (HADDR[7:0] == OFS_ERRSTAT) begin
        hrdata_r <= {30'h0, double_fault_flag, single_fault_flag};
      end else if (HADDR[7:0] == OFS_CIDX) begin
        hrdata_r <= {29'h0, cmd_idx_r};
      end else if (HADDR[7:0] == OFS_COBJ) begin
        hrdata_r <= {16'h0, (cmd_idx_r <= CCOB_IDX_MAX) ? ccob_r[cmd_idx_r] : 16'h0000};
      end else if (HADDR[7:0] == OFS_SEC) begin
        hrdata_r <= {24'h0, security_register};
      end else if (HADDR[7:0] == OFS_PPROT) begin
        hrdata_r <= {24'h0, program_protect_register};
      end else if (HADDR[7:0] == OFS_DPROT) begin
        hrdata_r <= {24'h0, data_protect_register};
      end else if (HADDR[7:0] == OFS_OPT) begin
        hrdata_r <= {24'h0, option_register};
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  assign wr_cfg     = dph_wr_r && (dph_addr_r == OFS_CFG);
  assign wr_errcfg  = dph_wr_r && (dph_addr_r == OFS_ERRCFG);
  assign wr_stat    = dph_wr_r && (dph_addr_r == OFS_STAT);
  assign wr_errstat = dph_wr_r && (dph_addr_r == OFS_ERRSTAT);
  // command registers writable only with the complete flag set
  assign wr_cidx    = dph_wr_r && (dph_addr_r == OFS_CIDX) && cmd_complete_flag; // [RQ16] [RQ17]
  assign wr_cobj    = dph_wr_r && (dph_addr_r == OFS_COBJ) && cmd_complete_flag; // [RQ16] [RQ17]
  assign launch     = wr_stat && HWDATA[STAT_CCF_BIT] && cmd_complete_flag && (state_r == S_IDLE);

  // ---------------------------------------------------------------
  // configuration and command registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_complete_irq_en <= 1'b0;
      single_fault_irq_en <= 1'b0;
      double_fault_irq_en <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cmd_complete_irq_en <= HWDATA[CFG_CMD_COMPLETE_IRQ_EN_BIT]; // [RQ19]
      end
      if (wr_errcfg) begin
        single_fault_irq_en <= HWDATA[ERR_SFD_BIT];
        double_fault_irq_en <= HWDATA[ERR_DFD_BIT];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_idx_r <= 3'b000;
      for (int i = 0; i < CCOB_DEPTH; i++) begin
        ccob_r[i] <= 16'h0000;
      end
    end else begin
      if (wr_cidx) begin
        cmd_idx_r <= HWDATA[2:0];
      end
      if (wr_cobj && (cmd_idx_r <= CCOB_IDX_MAX)) begin
        ccob_r[cmd_idx_r] <= HWDATA[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // flash read port and key compare
  // ---------------------------------------------------------------
  assign rd_done       = rd_pend_r && FL_RVALID;
  assign key_presented = ccob_r[3'(key_idx_r) + 3'd1];

  fsrc_key_chk u_key_chk (
    .presented (key_presented),
    .stored    (FL_RDATA),
    .match     (kc_match),
    .illegal   (kc_illegal)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FL_RD     <= 1'b0;
      FL_ADDR   <= 23'h000000;
      rd_pend_r <= 1'b0;
    end else begin
      FL_RD <= 1'b0;
      if (rd_done) begin
        rd_pend_r <= 1'b0;
      end else if (!rd_pend_r && !FL_RD) begin
        if (state_r == S_CFG0) begin
          FL_RD     <= 1'b1;
          FL_ADDR   <= FA_PROT;
          rd_pend_r <= 1'b1;
        end else if (state_r == S_CFG1) begin
          FL_RD     <= 1'b1;
          FL_ADDR   <= FA_SECW; // [RQ5]
          rd_pend_r <= 1'b1;
        end else if (state_r == S_KEY) begin
          FL_RD     <= 1'b1;
          FL_ADDR   <= FA_KEY0 + 23'({key_idx_r, 1'b0}); // [RQ7]
          rd_pend_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // any reset drops a running command here at once
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= S_HOLD; // [RQ18]
      hold_cnt_r <= '0;
      key_idx_r  <= 2'b00;
      key_ok_r   <= 1'b0;
      FL_CMD_START <= 1'b0;
    end else begin
      FL_CMD_START <= 1'b0;
      case (state_r)
        S_HOLD: begin
          hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
          if (hold_cnt_r == HOLD_W'(HOLD_CYC - 1)) begin
            state_r <= S_CFG0;
          end
        end
        S_CFG0: begin
          if (rd_done) begin
            state_r <= S_CFG1;
          end
        end
        S_CFG1: begin
          if (rd_done) begin
            state_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          key_idx_r <= 2'b00;
          key_ok_r  <= 1'b1;
          if (launch && !key_refused) begin
            if (ccob_r[0][15:8] == CMD_VERIFY_KEY) begin
              state_r <= S_KEY; // [RQ7] [RQ11]
            end else begin
              FL_CMD_START <= 1'b1;
              state_r      <= S_CMD;
            end
          end
        end
        S_KEY: begin
          if (rd_done) begin
            key_ok_r  <= key_ok_r && kc_match; // [RQ7]
            key_idx_r <= key_idx_r + 2'd1;
            if (key_idx_r == KEY_IDX_LAST) begin
              state_r <= S_IDLE;
            end
          end
        end
        S_CMD: begin
          if (FL_CMD_DONE) begin
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_HOLD;
        end
      endcase
    end
  end

  assign FL_CMD_WORD0 = ccob_r[0];
  assign FL_CMD_WORD1 = ccob_r[1];
  assign PF0_BLOCKED  = (state_r == S_KEY); // [RQ10]

  // ---------------------------------------------------------------
  // security, protection and option registers
  // ---------------------------------------------------------------
  // loaded only by the reset sequence, so a newly programmed byte waits for reset;
  // verify-key only alters the live state field, never flash or protection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      security_register        <= SEC_DEF; // [RQ14]
      program_protect_register <= PROT_DEF;
      data_protect_register    <= PROT_DEF;
      option_register          <= OPT_DEF;
      prot_lo_r                <= PROT_DEF;
      cfg_err_r                <= 1'b0;
      key_lock_r               <= 1'b0;
    end else begin
      if (state_r == S_CFG0 && rd_done) begin
        cfg_err_r <= FL_DBL_FAULT;
        prot_lo_r <= FL_RDATA[7:0];
        if (!FL_DBL_FAULT) begin
          program_protect_register <= FL_RDATA[15:8]; // [RQ14]
        end
      end
      if (state_r == S_CFG1 && rd_done) begin
        if (!FL_DBL_FAULT && !cfg_err_r) begin
          data_protect_register <= prot_lo_r; // [RQ14]
          option_register       <= FL_RDATA[15:8];
          security_register     <= FL_RDATA[7:0]; // [RQ5] [RQ6]
        end else begin
          program_protect_register <= PROT_DEF; // [RQ14]
          data_protect_register    <= PROT_DEF;
          option_register          <= OPT_DEF;
          security_register        <= SEC_DEF;
        end
      end
      if (state_r == S_KEY && rd_done) begin
        if (kc_illegal || !kc_match) begin
          key_lock_r <= 1'b1; // [RQ11]
        end else if (key_idx_r == KEY_IDX_LAST && key_ok_r) begin
          security_register[SEC_LSB +: 2] <= SEC_UNSECURE; // [RQ8] [RQ12]
        end
      end
      if (state_r == S_CMD && FL_CMD_DONE && FL_CMD_PASS && SPECIAL_MODE &&
          ccob_r[0][15:8] == CMD_EVERIFY_ALL) begin
        security_register[SEC_LSB +: 2] <= SEC_UNSECURE; // [RQ13]
      end
    end
  end

  // ---------------------------------------------------------------
  // status and fault flags
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_complete_flag   <= 1'b0; // [RQ17]
      acc_err_r           <= 1'b0;
      verify_error_status <= 2'b00;
    end else begin
      if (state_r == S_CFG1 && rd_done) begin
        cmd_complete_flag <= 1'b1; // [RQ17]
      end else if (launch && !key_refused) begin
        cmd_complete_flag <= 1'b0; // [RQ11]
      end else if ((state_r == S_KEY && rd_done && key_idx_r == KEY_IDX_LAST) ||
                   (state_r == S_CMD && FL_CMD_DONE)) begin
        cmd_complete_flag <= 1'b1;
      end
      if ((state_r == S_CFG0 || state_r == S_CFG1) && rd_done && FL_DBL_FAULT) begin
        verify_error_status <= VERR_BOTH; // [RQ15]
      end else if (launch) begin
        verify_error_status <= 2'b00;
      end
      if (launch && key_refused) begin
        acc_err_r <= 1'b1; // [RQ11]
      end else if (wr_stat && HWDATA[STAT_ACCERR_BIT]) begin
        acc_err_r <= 1'b0;
      end
    end
  end

  // fault flags: a new fault wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      single_fault_flag <= 1'b0;
      double_fault_flag <= 1'b0;
    end else begin
      if (rd_done && FL_SGL_FAULT) begin
        single_fault_flag <= 1'b1;
      end else if (wr_errstat && HWDATA[ERR_SFD_BIT]) begin
        single_fault_flag <= 1'b0;
      end
      if (rd_done && FL_DBL_FAULT) begin
        double_fault_flag <= 1'b1;
      end else if (wr_errstat && HWDATA[ERR_DFD_BIT]) begin
        double_fault_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts and low power
  // ---------------------------------------------------------------
  // levels straight from flags and enables, no wait-mode gating
  assign CMD_IRQ  = cmd_complete_flag && cmd_complete_irq_en; // [RQ1] [RQ3] [RQ20]
  assign ERR_IRQ  = (double_fault_flag && double_fault_irq_en) ||
                    (single_fault_flag && single_fault_irq_en); // [RQ2] [RQ20]
  assign STOP_ACK = STOP_REQ && cmd_complete_flag && (state_r == S_IDLE); // [RQ4]

endmodule
`default_nettype wire

// >>> testbench/fsrc_ctrl_properties.sv
// fsrc_ctrl_props: port-level checks of the flash control block.
// assumes: bound into every fsrc_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module fsrc_ctrl_props
  import fsrc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic        CMD_IRQ,
  input wire logic        STOP_REQ,
  input wire logic        STOP_ACK,
  input wire logic        PF0_BLOCKED,
  input wire logic        FL_RD,
  input wire logic [22:0] FL_ADDR,
  input wire logic        FL_CMD_START,
  input wire logic        FL_CMD_DONE
);
  // ----
  // helper state
  // ----
  logic [7:0] hold_cnt_r;
  logic       busy_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) hold_cnt_r <= 8'h00;
    else if (hold_cnt_r != 8'hff) hold_cnt_r <= hold_cnt_r + 8'h01;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) busy_r <= 1'b0;
    else if (FL_CMD_START) busy_r <= 1'b1;
    else if (FL_CMD_DONE) busy_r <= 1'b0;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // assertions
  // ----
  hold_low_a: assert property (hold_cnt_r < HOLD_CYC - 2 |-> !HREADYOUT)
    else $error("bus answered during hold");
  hold_end_a: assert property (hold_cnt_r > HOLD_CYC |-> HREADYOUT)
    else $error("bus stalled after hold");
  first_cfg_a: assert property ($rose(HREADYOUT) |-> ##[0:2] (FL_RD && FL_ADDR == FA_PROT))
    else $error("no config read after hold");
  rd_pulse_a: assert property (FL_RD |=> !FL_RD)
    else $error("flash read not a pulse");
  no_irq_hold_a: assert property (!HREADYOUT |-> !CMD_IRQ)
    else $error("command irq during hold");
  launch_irq_a: assert property (FL_CMD_START |-> !CMD_IRQ)
    else $error("command irq while launching");
  stop_busy_a: assert property (busy_r |-> !STOP_ACK)
    else $error("stop granted while busy");
  stop_req_a: assert property (STOP_ACK |-> STOP_REQ)
    else $error("stop granted unrequested");
  key_block_a: assert property ($rose(PF0_BLOCKED) |-> ##[0:1] (FL_RD && FL_ADDR == FA_KEY0))
    else $error("block 0 blocked without key read");
  rdata_hold_a: assert property ($changed(HRDATA) |-> $past(HSEL && HTRANS[1] && !HWRITE && HREADY && HREADYOUT))
    else $error("read data changed without read");
endmodule
bind fsrc_ctrl fsrc_ctrl_props i_props (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .CMD_IRQ(CMD_IRQ),
  .STOP_REQ(STOP_REQ), .STOP_ACK(STOP_ACK), .PF0_BLOCKED(PF0_BLOCKED), .FL_RD(FL_RD),
  .FL_ADDR(FL_ADDR), .FL_CMD_START(FL_CMD_START), .FL_CMD_DONE(FL_CMD_DONE));
`default_nettype wire

// >>> testbench/fsrc_flash_model.sv
// fsrc_flash_model: flash array and command engine on the FL_* ports.
// assumes: same clock and reset as the controller.
`timescale 1ns/1ps
`default_nettype none
module fsrc_flash_model
  import fsrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        rd,
  input  wire logic [22:0] addr,
  output logic [15:0]      rdata,
  output logic             rvalid,
  output logic             sgl,
  output logic             dbl,
  input  wire logic        start,
  output logic             done,
  output logic             pass,
  input  wire logic        sgl_en,
  input  wire logic        dbl_en
);
  // ----
  // read port and command engine
  // ----
  logic [22:0] a_r;
  int          rc;
  int          cc;
  function automatic logic [15:0] word(input logic [22:0] a);
    if (a == FA_PROT) return 16'h3c5a;
    if (a == FA_SECW) return 16'h7e83;
    return 16'h1111 * {14'h0, a[2:1]} + 16'h1111;
  endfunction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc <= 0;
      cc <= 0;
      a_r <= 23'h0;
      rvalid <= 1'b0;
      rdata <= 16'h0;
      done <= 1'b0;
      pass <= 1'b0;
    end else begin
      rvalid <= (rc == 1);
      rdata <= (rc == 1) ? word(a_r) : ~rdata;
      if (rd) begin
        a_r <= addr;
        rc <= 8;
      end else if (rc != 0) rc <= rc - 1;
      if (start) cc <= 30;
      else if (cc != 0) cc <= cc - 1;
      done <= (cc == 1);
      pass <= (cc == 1) ? 1'b1 : ~pass;
    end
  end
  assign sgl = rvalid & sgl_en;
  assign dbl = rvalid & dbl_en;
endmodule
`default_nettype wire

// >>> testbench/fsrc_ctrl_tb.sv
// fsrc_ctrl_tb: bus-level tests of the flash control block.
// assumes: one AHB-Lite slave; flash model answers the FL_* ports.
`timescale 1ns/1ps
`default_nettype none
module fsrc_ctrl_tb;
  import fsrc_pkg::*;
  // ----
  // signals and instances
  // ----
  logic        CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, STOP_REQ = 0, SPECIAL_MODE = 0;
  logic        sgl_en = 0, dbl_en = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
  logic [1:0]  HTRANS = 0;
  logic [2:0]  HSIZE = 3'h2;
  logic        HREADYOUT, HRESP, CMD_IRQ, ERR_IRQ, STOP_ACK, PF0_BLOCKED, FL_RD, FL_RVALID;
  logic        FL_SGL_FAULT, FL_DBL_FAULT, FL_CMD_START, FL_CMD_DONE, FL_CMD_PASS;
  logic [22:0] FL_ADDR;
  logic [15:0] FL_RDATA;
  wire logic   HREADY = HREADYOUT;
  int          mismatches = 0, samples_checked = 0;
  fsrc_ctrl i_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMD_IRQ(CMD_IRQ), .ERR_IRQ(ERR_IRQ), .STOP_REQ(STOP_REQ),
    .STOP_ACK(STOP_ACK), .SPECIAL_MODE(SPECIAL_MODE), .PF0_BLOCKED(PF0_BLOCKED), .FL_RD(FL_RD),
    .FL_ADDR(FL_ADDR), .FL_RDATA(FL_RDATA), .FL_RVALID(FL_RVALID), .FL_SGL_FAULT(FL_SGL_FAULT),
    .FL_DBL_FAULT(FL_DBL_FAULT), .FL_CMD_START(FL_CMD_START), .FL_CMD_WORD0(), .FL_CMD_WORD1(),
    .FL_CMD_DONE(FL_CMD_DONE), .FL_CMD_PASS(FL_CMD_PASS));
  fsrc_flash_model i_flash (.clk(CLK), .rst_n(RST_N), .rd(FL_RD), .addr(FL_ADDR), .rdata(FL_RDATA),
    .rvalid(FL_RVALID), .sgl(FL_SGL_FAULT), .dbl(FL_DBL_FAULT), .start(FL_CMD_START),
    .done(FL_CMD_DONE), .pass(FL_CMD_PASS), .sgl_en(sgl_en), .dbl_en(dbl_en));
  initial forever #2 CLK = ~CLK;
  // ----
  // bus tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_rdy(output logic [31:0] d);
    logic ok;
    do begin
      @(negedge CLK);
      ok = (HREADYOUT === 1'b1);
      d = HRDATA;
      @(posedge CLK);
    end while (!ok);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    wait_rdy(d);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    wait_rdy(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(n, e, d & m);
  endtask
  task automatic wait_flag;
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, OFS_STAT, 32'h0, d);
      if (d[STAT_CCF_BIT] === 1'b1) break;
    end
  endtask
  task automatic cmd(input logic [15:0] code, input logic [15:0] k0);
    wr(OFS_CIDX, 32'h0);
    wr(OFS_COBJ, {16'h0, code});
    for (int i = 1; i <= NUM_KEYS; i++) begin
      wr(OFS_CIDX, 32'(i));
      wr(OFS_COBJ, (i == 1) ? {16'h0, k0} : 32'h1111 * 32'(i));
    end
    wr(OFS_STAT, 32'h80);
  endtask
  task automatic do_reset;
    RST_N <= 1'b0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  // ----
  // test sequence
  // ----
  initial begin
    do_reset();
    wr(OFS_CIDX, 32'h3);
    rdc("cidx ignored", OFS_CIDX, 32'h0);
    rdc("stat in reset", OFS_STAT, 32'h0);
    wait_flag();
    rdc("stat", OFS_STAT, 32'h80);
    rdc("sec", OFS_SEC, 32'h83);
    rdc("pprot", OFS_PPROT, 32'h3c);
    rdc("dprot", OFS_DPROT, 32'h5a);
    rdc("opt", OFS_OPT, 32'h7e);
    rdc("unmapped", 8'h30, 32'h0);
    wr(OFS_CFG, 32'h1);
    @(negedge CLK);
    chk("cmd irq", 32'h1, CMD_IRQ);
    wr(OFS_ERRCFG, 32'h1);
    sgl_en <= 1'b1;
    cmd({CMD_VERIFY_KEY, 8'h0}, 16'h1111);
    wait_flag();
    sgl_en <= 1'b0;
    @(negedge CLK);
    chk("cmd irq done", 32'h1, CMD_IRQ);
    chk("err irq", 32'h1, ERR_IRQ);
    rdc("sec unsecure", OFS_SEC, 32'h82);
    rdc("pprot kept", OFS_PPROT, 32'h3c);
    rdc("errstat", OFS_ERRSTAT, 32'h1);
    wr(OFS_ERRSTAT, 32'h1);
    @(negedge CLK);
    chk("err irq clear", 32'h0, ERR_IRQ);
    cmd({CMD_VERIFY_KEY, 8'h0}, KEY_ALL1);
    wait_flag();
    cmd({CMD_VERIFY_KEY, 8'h0}, 16'h1111);
    wait_flag();
    rdc("key locked", OFS_STAT, 32'ha0, 32'ha0);
    cmd({CMD_EVERIFY_ALL, 8'h0}, 16'h1111);
    repeat (5) @(posedge CLK);
    dbl_en <= 1'b1;
    do_reset();
    wait_flag();
    dbl_en <= 1'b0;
    rdc("stat dbl", OFS_STAT, 32'h83);
    rdc("sec default", OFS_SEC, 32'hff);
    rdc("pprot default", OFS_PPROT, 32'h0);
    rdc("opt default", OFS_OPT, 32'hff);
    SPECIAL_MODE <= 1'b1;
    STOP_REQ <= 1'b1;
    cmd({CMD_EVERIFY_ALL, 8'h0}, 16'h1111);
    repeat (2) @(negedge CLK);
    chk("stop while busy", 32'h0, STOP_ACK);
    wait_flag();
    @(negedge CLK);
    chk("stop granted", 32'h1, STOP_ACK);
    rdc("sec erased", OFS_SEC, 32'hfe);
    wrap_up();
  end
endmodule
`default_nettype wire
